// *** design/ucode_field_defs.vh ***
// Overview of operation
// - Format bit picks special or standard fields
// - Constant flag picks constant or register fields
// - Nonzero count shifts directly, zero uses register
// - Constant byte lands in selected lane only
// - Ten-bit literal is position over constant
// - Memory request field forwarded to memory unit
// - Hold register loads shifter output on request
// - Write select picks arithmetic or shifter result
// - Length field governs codes, size, extension, bytes
// - Address field loads arithmetic output or holds
// - Multi-purpose field performs exactly one function
// - Standard words default coordination and retire off
// - Special words hold, no shift, zero count
// - Standard constant: zero count, ignore B select
// - Special constant: field two off, no inhibit
// - Retire inhibit blocks instruction and queue retire
// - Sequencer final-cycle codes flagged for fault logic
// - Memory-data and scratch registers accept listed writers
// - GPRs except R15 accept listed writers only
// - Three-stage pipeline, in-order retirement
// - Shifter right-shifts A:B quadword 0 to 63
// - Hold and address registers load bypassing result
`ifndef UCODE_FIELD_DEFS_VH
`define UCODE_FIELD_DEFS_VH
// Microword layout (48 bits)
`define UW_WIDTH      48
`define UW_FMT        0
`define UW_LIT        1
`define UW_ALU_LO     2
`define UW_ALU_HI     5
`define UW_MRQ_LO     6
`define UW_MRQ_HI     10
`define UW_A_LO       11
`define UW_A_HI       16
`define UW_DST_LO     17
`define UW_DST_HI     22
`define UW_W          23
`define UW_L          24
`define UW_V          25
`define UW_MISC_LO    26
`define UW_MISC_HI    30
`define UW_Q          31
`define UW_SHF_LO     32
`define UW_SHF_HI     35
`define UW_M1_LO      31
`define UW_M1_HI      35
`define UW_M2_LO      36
`define UW_M2_HI      37
`define UW_DISRET     38
`define UW_VAL_LO     36
`define UW_VAL_HI     40
`define UW_B_LO       41
`define UW_B_HI       45
`define UW_CONST_LO   38
`define UW_CONST_HI   45
`define UW_POS_LO     46
`define UW_POS_HI     47
// Multi-purpose field codes
`define MISC_NOP      5'h00
`define MISC_CC       5'h01
`define MISC_DL_BYTE  5'h02
`define MISC_DL_WORD  5'h03
`define MISC_DL_LONG  5'h04
`define MISC_SET_FLAG 5'h05
`define MISC_CLR_FLAG 5'h06
`define MISC_CONST10  5'h07
`define MISC_COORD    5'h08
// Coordination field one codes
`define M1_NOP        5'h00
`define M1_SET_FLAG   5'h01
`define M1_CLR_FLAG   5'h02
// Shifter function codes
`define SHF_NOP       4'h0
`define SHF_SHIFT     4'h1
`define SHF_PASS_A    4'h2
`define SHF_PASS_B    4'h3
// ALU function codes
`define ALU_PASS_A    4'h0
`define ALU_PASS_B    4'h1
`define ALU_ADD       4'h2
`define ALU_SUB       4'h3
`define ALU_AND       4'h4
`define ALU_OR        4'h5
`define ALU_XOR       4'h6
// Data lengths
`define LEN_BYTE      2'h0
`define LEN_WORD      2'h1
`define LEN_LONG      2'h2
// Sequencer final-cycle codes
`define SEQUENCER_FORMAT_FIELD_LAST  2'h1
`define SEQ_SEL_LAST  3'h1
`define SEQ_SEL_LOVF  3'h2
// Register classes and write sources
`define CLS_MD        2'h0
`define CLS_SCRATCH   2'h1
`define CLS_GPR       2'h2
`define CLS_STATE     2'h3
`define SRC_IBOX_MEM  3'h0
`define SRC_IBOX_DIR  3'h1
`define SRC_EXEC_MEM  3'h2
`define SRC_ALU_SHF   3'h3
`define SRC_FLOAT     3'h4
`define SRC_IBOX_IPR  3'h5
`define SRC_EXEC      3'h6
`define PC_INDEX      4'hf
// APB register map
`define REG_CTRL      8'h00
`define REG_STATUS    8'h04
`define REG_HOLD      8'h08
`define REG_VADDR     8'h0c
`define CTRL_SC_LO    0
`define CTRL_SC_HI    5
`define CTRL_DL_LO    8
`define CTRL_DL_HI    9
`define SC_RESET      6'h00
`define DL_RESET      2'h2
`endif

// *** design/exec_microword_field_decoder.v ***
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "ucode_field_defs.vh"
module exec_microword_field_decoder (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  // Microword from control store
  input  wire        uword_valid,
  input  wire [47:0] uword,
  input  wire [1:0]  sequencer_format_field,
  input  wire [2:0]  sequencer_select_field,
  // Operand selects, then operands one cycle later
  output wire [5:0]  a_select,
  output wire [4:0]  b_select,
  output wire        b_select_used,
  input  wire [31:0] operand_bus_a,
  input  wire [31:0] operand_bus_b_reg,
  // Result
  output reg  [31:0] result_bus,
  output reg         result_valid,
  output reg  [5:0]  result_destination_sel,
  output reg  [3:0]  byte_write_en,
  output reg         cc_neg,
  output reg         cc_zero,
  output reg         cc_update,
  // Memory unit
  output reg  [4:0]  mem_request_field,
  output reg         mem_request_valid,
  output reg  [1:0]  mem_size,
  // Coordination
  output reg  [4:0]  coord_field_one,
  output reg  [1:0]  coord_field_two,
  output reg         coord_misc,
  output reg         retire_inhibit,
  output reg         retire_allowed,
  output reg         last_cycle,
  output reg         last_cycle_overflow,
  output reg         result_selector_ctl,
  // Register file write check
  input  wire [1:0]  wr_class,
  input  wire [2:0]  wr_source,
  input  wire [3:0]  wr_index,
  output reg         wr_allowed
);

  // Stage 1 registers
  reg [47:0] uw_q;
  reg        s1_v_q;
  reg [1:0]  sfmt_q;
  reg [2:0]  ssel_q;
  // Architectural registers of the block
  reg [5:0]  shift_count_reg_q;
  reg [1:0]  data_length_reg_q;
  reg        state_flag_q;
  reg [31:0] hold_q;
  reg [31:0] virt_addr_reg_q;

  // Field extraction from stage 1
  wire       fmt   = uw_q[`UW_FMT];
  wire       const_variant_flag   = uw_q[`UW_LIT];
  wire [3:0] alu_f = uw_q[`UW_ALU_HI:`UW_ALU_LO];
  wire [4:0] misc  = uw_q[`UW_MISC_HI:`UW_MISC_LO];
  wire [1:0] pos   = uw_q[`UW_POS_HI:`UW_POS_LO];
  wire [7:0] cbyte = uw_q[`UW_CONST_HI:`UW_CONST_LO];

  // Format defaults for fields absent in this format
  wire       q_load      = ~fmt & uw_q[`UW_Q];
  wire [3:0] shifter_function_field =
    fmt ? `SHF_NOP : uw_q[`UW_SHF_HI:`UW_SHF_LO];
  wire [4:0] shift_amount_field =
    (fmt | const_variant_flag) ? 5'h00 : uw_q[`UW_VAL_HI:`UW_VAL_LO];
  wire [4:0] m1_dec = fmt ? uw_q[`UW_M1_HI:`UW_M1_LO] : `M1_NOP;
  wire [1:0] m2_dec = (fmt & ~const_variant_flag) ? uw_q[`UW_M2_HI:`UW_M2_LO] : 2'h0;
  wire       dis_ret = fmt & ~const_variant_flag & uw_q[`UW_DISRET];

  // Operand selects; B select is ignored by constant words
  assign a_select      = uw_q[`UW_A_HI:`UW_A_LO];
  assign b_select      = uw_q[`UW_B_HI:`UW_B_LO];
  assign b_select_used = ~const_variant_flag;

  // Stage 2 registers: microword decoded, constant captured; operands stay unregistered
  reg [47:0] uw2_q;
  reg        s2_v_q;
  reg [1:0]  sfmt2_q;
  reg [2:0]  ssel2_q;
  reg [3:0]  shf2_q;
  reg [5:0]  amt2_q;
  reg        qld2_q;
  reg [4:0]  m1_2_q;
  reg [1:0]  m2_2_q;
  reg        dr2_q;
  reg [31:0] const2_q;
  reg        lit2_q;

  // Constant generator
  reg [31:0] const_bus;
  always @* begin
    const_bus = 32'h0000_0000;
    if (misc == `MISC_CONST10)
      const_bus = {22'h00_0000, pos, cbyte};
    else
      const_bus[{pos, 3'h0} +: 8] = cbyte;
  end

  // Direct count 1..31, else the shift-count register, or zero in special and constant words
  wire [5:0] amt = (shift_amount_field != 5'h00) ? {1'b0, shift_amount_field}
                 : ((fmt | const_variant_flag) ? 6'h00 : shift_count_reg_q);

  // Stage 2 operand view
  wire [31:0] bus_a = operand_bus_a;
  wire [31:0] operand_bus_b = lit2_q ? const2_q : operand_bus_b_reg;
  wire [3:0]  alu2 = uw2_q[`UW_ALU_HI:`UW_ALU_LO];
  wire [4:0]  misc2f = uw2_q[`UW_MISC_HI:`UW_MISC_LO];

  // Shifter: A is the upper longword of the quadword
  wire [63:0] quad = {bus_a, operand_bus_b};
  wire [63:0] quad_sh = quad >> amt2_q;
  reg  [31:0] shf_out;
  always @* begin
    case (shf2_q)
      `SHF_SHIFT:  shf_out = quad_sh[31:0];
      `SHF_PASS_A: shf_out = bus_a;
      `SHF_PASS_B: shf_out = operand_bus_b;
      default:     shf_out = operand_bus_b;
    endcase
  end

  reg [31:0] alu_out;
  always @* begin
    case (alu2)
      `ALU_PASS_A: alu_out = bus_a;
      `ALU_PASS_B: alu_out = operand_bus_b;
      `ALU_ADD:    alu_out = bus_a + operand_bus_b;
      `ALU_SUB:    alu_out = bus_a - operand_bus_b;
      `ALU_AND:    alu_out = bus_a & operand_bus_b;
      `ALU_OR:     alu_out = bus_a | operand_bus_b;
      `ALU_XOR:    alu_out = bus_a ^ operand_bus_b;
      default:     alu_out = bus_a;
    endcase
  end

  // Effective length; a length set in this word applies from the next word
  wire [1:0] eff_len = uw2_q[`UW_L] ? data_length_reg_q : `LEN_LONG;
  wire [31:0] wsel = uw2_q[`UW_W] ? shf_out : alu_out;
  reg  [31:0] wext;
  reg  [3:0]  ben;
  reg         sign_bit;
  always @* begin
    case (eff_len)
      `LEN_BYTE: begin
        wext = {24'h00_0000, wsel[7:0]};
        ben = 4'h1;
        sign_bit = wsel[7];
      end
      `LEN_WORD: begin
        wext = {16'h0000, wsel[15:0]};
        ben = 4'h3;
        sign_bit = wsel[15];
      end
      default: begin
        wext = wsel;
        ben = 4'hf;
        sign_bit = wsel[31];
      end
    endcase
  end

  // Register-file writer admission, evaluated combinationally
  always @* begin
    case (wr_class)
      `CLS_MD:      wr_allowed = (wr_source == `SRC_IBOX_MEM) |
                                 (wr_source == `SRC_IBOX_DIR);
      `CLS_SCRATCH: wr_allowed = (wr_source == `SRC_EXEC_MEM) |
                                 (wr_source == `SRC_ALU_SHF) |
                                 (wr_source == `SRC_FLOAT) |
                                 (wr_source == `SRC_IBOX_IPR);
      `CLS_GPR:     wr_allowed = (wr_index != `PC_INDEX) &
                                 ((wr_source == `SRC_EXEC_MEM) |
                                  (wr_source == `SRC_ALU_SHF) |
                                  (wr_source == `SRC_IBOX_DIR));
      default:      wr_allowed = (wr_source == `SRC_EXEC);
    endcase
  end

  // APB: one wait-free access phase, read data captured in setup
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pwrite;
  wire mapped    = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) |
                   (paddr == `REG_HOLD) | (paddr == `REG_VADDR);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Pipeline: stage1 decode, stage2 execute, stage3 result
  always @(posedge clk) begin
    if (rst) begin
      uw_q   <= 48'h0000_0000_0000;
      s1_v_q <= 1'b0;
      sfmt_q <= 2'h0;
      ssel_q <= 3'h0;
      uw2_q  <= 48'h0000_0000_0000;
      s2_v_q <= 1'b0;
      sfmt2_q <= 2'h0;
      ssel2_q <= 3'h0;
      shf2_q <= `SHF_NOP;
      amt2_q <= 6'h00;
      qld2_q <= 1'b0;
      m1_2_q <= `M1_NOP;
      m2_2_q <= 2'h0;
      dr2_q  <= 1'b0;
      const2_q <= 32'h0000_0000;
      lit2_q <= 1'b0;
    end else begin
      uw_q   <= uword_valid ? uword : 48'h0000_0000_0000;
      s1_v_q <= uword_valid;
      sfmt_q <= sequencer_format_field;
      ssel_q <= sequencer_select_field;
      uw2_q  <= uw_q;
      s2_v_q <= s1_v_q;
      sfmt2_q <= sfmt_q;
      ssel2_q <= ssel_q;
      shf2_q <= shifter_function_field;
      amt2_q <= amt;
      qld2_q <= q_load;
      m1_2_q <= m1_dec;
      m2_2_q <= m2_dec;
      dr2_q  <= dis_ret;
      const2_q <= const_bus;
      lit2_q <= const_variant_flag;
    end
  end

  wire fin  = (sfmt2_q == `SEQUENCER_FORMAT_FIELD_LAST) & (ssel2_q == `SEQ_SEL_LAST);
  wire finv = (sfmt2_q == `SEQUENCER_FORMAT_FIELD_LAST) & (ssel2_q == `SEQ_SEL_LOVF);
  wire ex   = s2_v_q;

  always @(posedge clk) begin
    if (rst) begin
      result_bus <= 32'h0000_0000;
      result_valid <= 1'b0;
      result_destination_sel <= 6'h00;
      byte_write_en <= 4'h0;
      cc_neg <= 1'b0;
      cc_zero <= 1'b0;
      cc_update <= 1'b0;
      mem_request_field <= 5'h00;
      mem_request_valid <= 1'b0;
      mem_size <= `LEN_LONG;
      coord_field_one <= `M1_NOP;
      coord_field_two <= 2'h0;
      coord_misc <= 1'b0;
      retire_inhibit <= 1'b0;
      retire_allowed <= 1'b0;
      last_cycle <= 1'b0;
      last_cycle_overflow <= 1'b0;
      result_selector_ctl <= 1'b0;
      hold_q <= 32'h0000_0000;
      virt_addr_reg_q <= 32'h0000_0000;
      state_flag_q <= 1'b0;
      shift_count_reg_q <= `SC_RESET;
      data_length_reg_q <= `DL_RESET;
    end else begin
      result_bus <= wext;
      result_valid <= ex;
      result_destination_sel <= uw2_q[`UW_DST_HI:`UW_DST_LO];
      byte_write_en <= ex ? ben : 4'h0;
      cc_neg <= sign_bit;
      cc_zero <= (wext == 32'h0000_0000);
      cc_update <= ex & (misc2f == `MISC_CC);
      mem_request_field <= uw2_q[`UW_MRQ_HI:`UW_MRQ_LO];
      mem_request_valid <= ex & (uw2_q[`UW_MRQ_HI:`UW_MRQ_LO] != 5'h00);
      mem_size <= eff_len;
      coord_field_one <= ex ? m1_2_q : `M1_NOP;
      coord_field_two <= ex ? m2_2_q : 2'h0;
      coord_misc <= ex & (misc2f == `MISC_COORD);
      retire_inhibit <= ex & dr2_q;
      retire_allowed <= ex & (fin | finv) & ~dr2_q;
      last_cycle <= ex & fin;
      last_cycle_overflow <= ex & finv;
      result_selector_ctl <= ex & (fin | finv);
      if (ex & qld2_q)
        hold_q <= shf_out;
      if (ex & uw2_q[`UW_V])
        virt_addr_reg_q <= alu_out;
      // Microword set actions take priority over clear actions
      if (ex & ((misc2f == `MISC_SET_FLAG) | (m1_2_q == `M1_SET_FLAG)))
        state_flag_q <= 1'b1;
      else if (ex & ((misc2f == `MISC_CLR_FLAG) | (m1_2_q == `M1_CLR_FLAG)))
        state_flag_q <= 1'b0;
      if (apb_wr & (paddr == `REG_CTRL))
        shift_count_reg_q <= pwdata[`CTRL_SC_HI:`CTRL_SC_LO];
      // A microword length setting beats a software write in the same cycle
      if (ex & (misc2f == `MISC_DL_BYTE))
        data_length_reg_q <= `LEN_BYTE;
      else if (ex & (misc2f == `MISC_DL_WORD))
        data_length_reg_q <= `LEN_WORD;
      else if (ex & (misc2f == `MISC_DL_LONG))
        data_length_reg_q <= `LEN_LONG;
      else if (apb_wr & (paddr == `REG_CTRL))
        data_length_reg_q <= pwdata[`CTRL_DL_HI:`CTRL_DL_LO];
    end
  end

  // Read data register
  always @(posedge clk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
    end else if (apb_setup & ~pwrite) begin
      case (paddr)
        `REG_CTRL:   prdata <= {22'h00_0000, data_length_reg_q, 2'h0, shift_count_reg_q};
        `REG_STATUS: prdata <= {27'h000_0000, state_flag_q, retire_inhibit,
                                last_cycle_overflow, last_cycle, result_valid};
        `REG_HOLD:   prdata <= hold_q;
        `REG_VADDR:  prdata <= virt_addr_reg_q;
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // exec_microword_field_decoder

// *** verif/ucode_store_model.sv ***
`timescale 1ns/1ps
module ucode_store_model (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Request from bench
  input  wire        req,
  input  wire [47:0] req_word,
  input  wire [1:0]  req_fmt,
  input  wire [2:0]  req_sel,
  // Microword out
  output reg         uword_valid,
  output reg  [47:0] uword,
  output reg  [1:0]  sequencer_format_field,
  output reg  [2:0]  sequencer_select_field
);
  // Idle cycles invert the fields so a decoder that ignores valid is caught
  always @(posedge clk) begin
    if (rst) begin
      uword_valid            <= 1'b0;
      uword                  <= 48'h0;
      sequencer_format_field <= 2'h0;
      sequencer_select_field <= 3'h0;
    end else begin
      uword_valid            <= req;
      uword                  <= req ? req_word : ~uword;
      sequencer_format_field <= req ? req_fmt : ~sequencer_format_field;
      sequencer_select_field <= req ? req_sel : ~sequencer_select_field;
    end
  end
endmodule // ucode_store_model

// *** verif/exec_decoder_chk.sv ***
`timescale 1ns/1ps
`include "ucode_field_defs.vh"
module exec_decoder_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Microword side
  input wire        uword_valid,
  input wire [47:0] uword,
  input wire [1:0]  sequencer_format_field,
  input wire [2:0]  sequencer_select_field,
  input wire [31:0] operand_bus_a,
  input wire [31:0] operand_bus_b_reg,
  // Results
  input wire [31:0] result_bus,
  input wire        result_valid,
  input wire [4:0]  mem_request_field,
  input wire        mem_request_valid,
  input wire [1:0]  mem_size,
  input wire [4:0]  coord_field_one,
  input wire [1:0]  coord_field_two,
  input wire        retire_inhibit,
  input wire        retire_allowed,
  input wire        last_cycle,
  input wire        last_cycle_overflow,
  // Writer check
  input wire [1:0]  wr_class,
  input wire [3:0]  wr_index,
  input wire        wr_allowed
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_valid_lat; uword_valid |-> ##3 result_valid; endproperty
  a_valid_lat: assert property (p_valid_lat) else $error("result_valid missing");
  property p_bubble; !uword_valid |-> ##3 !result_valid && !mem_request_valid; endproperty
  a_bubble: assert property (p_bubble) else $error("pulse on bubble");
  property p_const_lane;
    uword_valid && uword[1] && uword[5:2] == `ALU_PASS_B && !uword[23]
      && uword[30:26] != `MISC_CONST10 |-> ##3 mem_size != `LEN_LONG
      || result_bus == ({24'h0, $past(uword[45:38], 3)} << (8 * $past(uword[47:46], 3)));
  endproperty
  a_const_lane: assert property (p_const_lane) else $error("constant lane wrong");
  property p_shift;
    uword_valid && !uword[0] && !uword[1] && uword[35:32] == `SHF_SHIFT && uword[23]
      && uword[40:36] != 5'h0 |-> ##3 mem_size != `LEN_LONG || result_bus ==
      32'({$past(operand_bus_a), $past(operand_bus_b_reg)} >> $past(uword[40:36], 3));
  endproperty
  a_shift: assert property (p_shift) else $error("direct shift wrong");
  property p_mrq;
    uword_valid && uword[10:6] != 5'h0 |-> ##3 mem_request_valid
      && mem_request_field == $past(uword[10:6], 3);
  endproperty
  a_mrq: assert property (p_mrq) else $error("memory request wrong");
  property p_std_defaults;
    uword_valid && !uword[0] |-> ##3 !retire_inhibit && coord_field_one == 5'h0
      && coord_field_two == 2'h0;
  endproperty
  a_std_defaults: assert property (p_std_defaults) else $error("std defaults");
  property p_inhibit;
    uword_valid && uword[0] && !uword[1] && uword[38] |-> ##3 retire_inhibit && !retire_allowed;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("retire not blocked");
  property p_lit_special;
    uword_valid && uword[0] && uword[1] |-> ##3 !retire_inhibit && coord_field_two == 2'h0;
  endproperty
  a_lit_special: assert property (p_lit_special) else $error("lit special");
  property p_last;
    uword_valid && sequencer_format_field == `SEQUENCER_FORMAT_FIELD_LAST
      && sequencer_select_field == `SEQ_SEL_LOVF |-> ##3 last_cycle_overflow && !last_cycle;
  endproperty
  a_last: assert property (p_last) else $error("overflow final cycle");
  property p_pc_write; wr_class == `CLS_GPR && wr_index == `PC_INDEX |-> !wr_allowed; endproperty
  a_pc_write: assert property (p_pc_write) else $error("pc write allowed");
endmodule // exec_decoder_chk
bind exec_microword_field_decoder exec_decoder_chk i_exec_decoder_chk (.clk, .rst,
  .uword_valid, .uword, .sequencer_format_field, .sequencer_select_field, .operand_bus_a,
  .operand_bus_b_reg, .result_bus, .result_valid, .mem_request_field, .mem_request_valid,
  .mem_size, .coord_field_one, .coord_field_two, .retire_inhibit, .retire_allowed,
  .last_cycle, .last_cycle_overflow, .wr_class, .wr_index, .wr_allowed);

// *** verif/tb.sv ***
`timescale 1ns/1ps
`include "ucode_field_defs.vh"
module tb;
  reg         clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, req = 0, e, ok;
  reg  [7:0]  paddr = 0;
  reg  [31:0] pwdata = 0, operand_bus_a = 0, operand_bus_b_reg = 0, r, hv;
  reg  [47:0] rw = 0;
  reg  [1:0]  rf = 0, wr_class = 0;
  reg  [2:0]  rs = 0, wr_source = 0;
  reg  [3:0]  wr_index = 0;
  reg  [63:0] sh;
  integer     i, bad_count = 0, n_checks = 0;
  wire        pready, pslverr, uword_valid, result_valid, mem_request_valid, retire_inhibit;
  wire        retire_allowed, last_cycle, last_cycle_overflow, wr_allowed;
  wire        cc_zero, cc_update, coord_misc, result_selector_ctl;
  wire [31:0] prdata, result_bus;
  wire [47:0] uword;
  wire [1:0]  sequencer_format_field, coord_field_two, mem_size;
  wire [2:0]  sequencer_select_field;
  wire [4:0]  mem_request_field, coord_field_one;
  wire [3:0]  byte_write_en;
  ucode_store_model i_ucode_store_model (.clk, .rst, .req, .req_word(rw), .req_fmt(rf),
    .req_sel(rs), .uword_valid, .uword, .sequencer_format_field, .sequencer_select_field);
  exec_microword_field_decoder i_exec_microword_field_decoder (.clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .uword_valid, .uword,
    .sequencer_format_field, .sequencer_select_field, .a_select(), .b_select(),
    .b_select_used(), .operand_bus_a, .operand_bus_b_reg, .result_bus, .result_valid,
    .result_destination_sel(), .byte_write_en, .cc_neg(), .cc_zero, .cc_update,
    .mem_request_field, .mem_request_valid, .mem_size, .coord_field_one, .coord_field_two,
    .coord_misc, .retire_inhibit, .retire_allowed, .last_cycle, .last_cycle_overflow,
    .result_selector_ctl, .wr_class, .wr_source, .wr_index, .wr_allowed);
  initial begin
    forever #5 clk = ~clk;
  end
  function [47:0] f(input integer lo, input [9:0] v);
    f = {38'h0, v} << lo;
  endfunction
  task chk(input [63:0] seen, input [63:0] exp, input [8*12:1] nm);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("unexpected %0s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task apb(input wr, input [7:0] a, input [31:0] d, output [31:0] rd, output er);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Word enters the model, is taken two edges later, operands follow its selects
  task word(input [47:0] w, input [1:0] fm, input [2:0] sl, input [31:0] a, input [31:0] b);
    @(posedge clk);
    req <= 1'b1;
    rw  <= w;
    rf  <= fm;
    rs  <= sl;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    operand_bus_a     <= a;
    operand_bus_b_reg <= b;
    @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count = bad_count + 1;
    end_sim;
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(mem_size, `LEN_LONG, "mem_size");
    apb(0, `REG_CTRL, 0, r, e);
    chk(r, 32'h200, "ctrl_rst");
    apb(0, 8'h10, 0, r, e);
    chk({e, r}, {1'b1, 32'h0}, "unmapped");
    apb(1, `REG_CTRL, 32'h205, r, e);
    apb(0, `REG_CTRL, 0, r, e);
    chk(r, 32'h205, "ctrl");
    for (i = 0; i < 8; i = i + 1) begin
      word(f(`UW_FMT, i / 4) | f(`UW_LIT, 1) | f(`UW_ALU_LO, `ALU_PASS_B) | f(36, 3)
           | f(`UW_CONST_LO, 8'ha5) | f(`UW_POS_LO, i % 4), 0, 0, 32'h1111_1111, ~32'h0);
      chk(result_bus, 32'ha5 << (8 * (i % 4)), "const_lane");
      chk({retire_inhibit, coord_field_two}, 3'h0, "lit_dflt");
    end
    word(f(`UW_LIT, 1) | f(`UW_ALU_LO, `ALU_PASS_B) | f(`UW_MISC_LO, `MISC_CONST10)
         | f(`UW_CONST_LO, 8'h3c) | f(`UW_POS_LO, 2), 0, 0, 32'h0, ~32'h0);
    chk(result_bus, 32'h23c, "const10");
    sh = {32'h1234_5678, 32'h9abc_def0} >> 4;
    hv = sh[31:0];
    word(f(`UW_SHF_LO, `SHF_SHIFT) | f(`UW_VAL_LO, 4) | f(`UW_W, 1) | f(`UW_Q, 1)
         | f(`UW_V, 1), 0, 0, 32'h1234_5678, 32'h9abc_def0);
    chk(result_bus, hv, "shift_val");
    chk({retire_inhibit, coord_field_one, coord_field_two}, 8'h0, "std_dflt");
    apb(0, `REG_HOLD, 0, r, e);
    chk(r, hv, "hold");
    apb(0, `REG_VADDR, 0, r, e);
    chk(r, 32'h1234_5678, "vaddr");
    sh = {32'hcafe_f00d, 32'h0bad_beef} >> 5;
    word(f(`UW_SHF_LO, `SHF_SHIFT) | f(`UW_W, 1), 0, 0, 32'hcafe_f00d, 32'h0bad_beef);
    chk(result_bus, sh[31:0], "shift_sc");
    word(f(`UW_FMT, 1) | f(`UW_M1_LO, `M1_SET_FLAG) | f(`UW_M2_LO, 2) | f(`UW_DISRET, 1),
         `SEQUENCER_FORMAT_FIELD_LAST, `SEQ_SEL_LAST, 32'h7777_0001, 32'h0);
    chk(result_bus, 32'h7777_0001, "alu_drv");
    chk({coord_field_one, coord_field_two, retire_inhibit}, 8'h0d, "special");
    chk({last_cycle, retire_allowed}, 2'b10, "inhibit");
    apb(0, `REG_HOLD, 0, r, e);
    chk(r, hv, "hold_kept");
    apb(0, `REG_VADDR, 0, r, e);
    chk(r, 32'h1234_5678, "va_kept");
    word(48'h0, `SEQUENCER_FORMAT_FIELD_LAST, `SEQ_SEL_LAST, 32'h0, 32'h0);
    chk({last_cycle, last_cycle_overflow, retire_allowed}, 3'b101, "last");
    chk(result_selector_ctl, 1'b1, "rsel_ctl");
    word(48'h0, `SEQUENCER_FORMAT_FIELD_LAST, `SEQ_SEL_LOVF, 32'h0, 32'h0);
    chk({last_cycle, last_cycle_overflow}, 2'b01, "last_ovf");
    word(f(`UW_MISC_LO, `MISC_CC), 0, 0, 32'h0, 32'h0);
    chk({cc_update, cc_zero, coord_misc}, 3'b110, "cc_upd");
    word(f(`UW_MISC_LO, `MISC_COORD), 0, 0, 32'h5, 32'h0);
    chk({cc_update, cc_zero, coord_misc}, 3'b001, "coord_misc");
    word(f(`UW_MISC_LO, `MISC_DL_BYTE), 0, 0, 32'h0, 32'h0);
    word(f(`UW_L, 1), 0, 0, 32'h1234_56ff, 32'h0);
    chk({mem_size, byte_write_en, result_bus}, {`LEN_BYTE, 4'h1, 32'hff}, "len_byte");
    word(f(`UW_MISC_LO, `MISC_DL_WORD), 0, 0, 32'h0, 32'h0);
    word(f(`UW_L, 1), 0, 0, 32'h1234_56ff, 32'h0);
    chk({mem_size, byte_write_en, result_bus}, {`LEN_WORD, 4'h3, 32'h56ff}, "len_word");
    word(f(`UW_MISC_LO, `MISC_DL_LONG), 0, 0, 32'h0, 32'h0);
    for (i = 0; i < 5; i = i + 1) begin
      word(f(`UW_MRQ_LO, i * 7), 0, 0, 32'h0, 32'h0);
      chk({mem_request_valid, mem_request_field}, {i != 0, 5'(i * 7)}, "mrq");
      chk({result_valid, byte_write_en}, 5'h1f, "bytes");
    end
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge clk);
      wr_class  <= i / 16;
      wr_source <= i / 2;
      wr_index  <= i[0] ? `PC_INDEX : 4'h3;
      #1;
      ok = (wr_class == `CLS_MD) ? wr_source <= `SRC_IBOX_DIR :
           (wr_class == `CLS_SCRATCH) ? wr_source >= `SRC_EXEC_MEM && wr_source <= `SRC_IBOX_IPR :
           (wr_class == `CLS_GPR) ? wr_source >= `SRC_IBOX_DIR && wr_source <= `SRC_ALU_SHF
           && wr_index != `PC_INDEX : wr_source == `SRC_EXEC;
      chk(wr_allowed, ok, "wr_allowed");
    end
    end_sim;
  end
endmodule // tb
